// *** logic/embedded_memory_block.sv ***
// Embedded memory block: dual-port RAM, single-port RAM, ROM and search.
// Assumes fabric logic on clk_in drives all inputs; no synchronisers.
//
`timescale 1ns/100ps
`include "emb_map.svh"
module embedded_memory_block
  import emb_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic in_ce_in,
  input wire logic out_ce_in,
  input wire logic in_clr_in,
  input wire logic out_clr_in,
  input wire logic glb_clr_in,
  input wire mode_t mode_in,
  input wire shape_t shape_in,
  input wire logic [`BYP_BITS-1:0] bypass_in,
  input wire logic encode_sel_in,
  input wire logic low_power_in,
  input wire logic block_used_in,
  input wire logic cfg_load_in,
  input wire logic we_sel_in,
  input wire logic we_local_in,
  input wire logic we_global_in,
  input wire logic rs_sel_in,
  input wire logic read_strobe_local_in,
  input wire logic read_strobe_global_in,
  input wire logic dc_write_in,
  input wire logic [`DIN_BITS-1:0] data_in,
  input wire logic [`ADDR_BITS-1:0] wr_addr_in,
  input wire logic [`ADDR_BITS-1:0] rd_addr_in,
  output logic [`RAM_BITS-1:0] data_out,
  output logic match_out,
  output logic upper_half_out,
  output logic busy_out
);
  logic in_rst_n;
  logic out_rst_n;
  logic in_go;
  logic out_go;
  logic we_raw;
  logic rs_raw;
  logic [`DIN_BITS-1:0] din_q;
  logic [`ADDR_BITS-1:0] waddr_q;
  logic [`ADDR_BITS-1:0] raddr_q;
  logic we_q;
  logic rs_q;
  logic [`DIN_BITS-1:0] din_e;
  logic [`ADDR_BITS-1:0] waddr_e;
  logic [`ADDR_BITS-1:0] raddr_e;
  logic we_e;
  logic rs_e;
  logic is_cam;
  logic [2:0] k;
  logic [3:0] wmask;
  logic [`ADDR_BITS-1:0] lane_mask;
  logic [`ADDR_BITS-1:0] wsh;
  logic [`ADDR_BITS-1:0] raddr_use;
  logic [`ADDR_BITS-1:0] rsh;
  logic [`ROW_BITS-1:0] wrow;
  logic [`ROW_BITS-1:0] rrow;
  logic [4:0] wlane;
  logic [3:0] rbase;
  logic wr_pulse;
  logic rd_take;
  logic search;
  logic [`RAM_BITS-1:0] mem_q [`RAM_ROWS];
  logic [`RAM_BITS-1:0] wbit_en;
  logic [`RAM_BITS-1:0] wbit_val;
  logic [`RAM_BITS-1:0] rword;
  logic [`RAM_BITS-1:0] rdata_c;
  logic [`RAM_BITS-1:0] rd_q;
  logic [`CAM_WORDS-1:0] hits_q;
  logic hit_any;
  logic [`CAM_ABITS-1:0] enc;
  cam_wr_t cw_q;
  logic [`CAM_ABITS-1:0] cw_addr_q;
  logic [`CAM_BITS-1:0] cw_data_q;
  logic cw_dc_q;
  logic phase_q;
  logic [`RAM_BITS-1:0] raw_data;
  logic raw_upper;
  logic [`RAM_BITS-1:0] lp_data_q;
  logic lp_match_q;
  logic lp_upper_q;
  logic [`RAM_BITS-1:0] src_data;
  logic src_match;
  logic src_upper;
  logic [`RAM_BITS-1:0] out_data_q;
  logic out_match_q;
  logic out_upper_q;

  cam_if cam ();

  // Each register group has its own clear plus the shared ones
  assign in_rst_n = arst_n_in & ~in_clr_in & ~glb_clr_in;
  assign out_rst_n = arst_n_in & ~out_clr_in & ~glb_clr_in;

  // An unused block freezes entirely, standing in for power-down
  assign in_go = ce_in & in_ce_in & block_used_in;
  assign out_go = ce_in & out_ce_in & block_used_in;

  // Enable source selection
  assign we_raw = we_sel_in ? we_global_in : we_local_in;
  assign rs_raw = rs_sel_in ? read_strobe_global_in
    : read_strobe_local_in;

  // Input stage on the input enable only
  always_ff @(posedge clk_in or negedge in_rst_n)
  begin
    if (!in_rst_n)
    begin
      din_q <= '0;
      waddr_q <= '0;
      raddr_q <= '0;
      we_q <= 1'b0;
      rs_q <= 1'b0;
    end
    else if (in_go)
    begin
      din_q <= data_in;
      waddr_q <= wr_addr_in;
      raddr_q <= rd_addr_in;
      we_q <= we_raw;
      rs_q <= rs_raw;
    end
  end

  // Per-signal register bypass
  assign din_e = bypass_in[`BYP_DIN] ? data_in : din_q;
  assign waddr_e = bypass_in[`BYP_WADDR] ? wr_addr_in : waddr_q;
  assign raddr_e = bypass_in[`BYP_RADDR] ? rd_addr_in : raddr_q;
  assign we_e = bypass_in[`BYP_WE] ? we_raw : we_q;
  assign rs_e = bypass_in[`BYP_RS] ? rs_raw : rs_q;

  // Shape decode: width is 16 >> k, depth 128 << k
  assign is_cam = (mode_in == MODE_CAM);
  assign k = shape_in;
  assign wmask = 4'hf >> k;
  assign lane_mask = ~(11'h7ff << k);
  assign wsh = waddr_e >> k;
  assign wrow = wsh[`ROW_BITS-1:0];
  assign wlane = 5'(waddr_e & lane_mask);
  // Single-port shares the write address; a write blocks the read
  assign raddr_use = (mode_in == MODE_SINGLE) ? waddr_e : raddr_e;
  assign rsh = raddr_use >> k;
  assign rrow = rsh[`ROW_BITS-1:0];
  assign rbase = 4'(raddr_use & lane_mask) << (3'd4 - k);

  // Self-timed write pulse; ROM only writes during configuration
  assign wr_pulse = in_go & we_e & ~is_cam &
    ((mode_in != MODE_ROM) | cfg_load_in);
  assign rd_take = in_go & rs_e & ~is_cam &
    ~((mode_in == MODE_SINGLE) & we_e);
  assign search = in_go & rs_e & is_cam;

  // Lane bits of the selected row take the narrow write data
  always_comb
  begin
    for (int i = 0; i < `RAM_BITS; i++)
    begin
      wbit_en[i] = ((5'(i) >> (3'd4 - k)) == wlane);
      wbit_val[i] = din_e[4'(i) & wmask];
    end
  end

  // Memory array, no reset: contents outlive clears
  always_ff @(posedge clk_in)
  begin
    if (wr_pulse)
    begin
      for (int i = 0; i < `RAM_BITS; i++)
      begin
        if (wbit_en[i])
        begin
          mem_q[wrow][i] <= wbit_val[i];
        end
      end
    end
  end

  // Narrow read, upper unused bits zero
  assign rword = mem_q[rrow];
  always_comb
  begin
    for (int j = 0; j < `RAM_BITS; j++)
    begin
      rdata_c[j] = (4'(j) <= wmask) ? rword[rbase + 4'(j)] : 1'b0;
    end
  end

  // Read data and search hits held on the input side
  always_ff @(posedge clk_in or negedge in_rst_n)
  begin
    if (!in_rst_n)
    begin
      rd_q <= '0;
      hits_q <= '0;
    end
    else if (rd_take)
    begin
      rd_q <= rdata_c;
    end
    else if (search)
    begin
      hits_q <= cam.hit;
    end
  end

  // Search array hookup
  assign cam.key = din_e;
  assign cam.wr_addr = cw_addr_q;
  assign cam.wr_data = (cw_q == CW_MASK) ? din_e : cw_data_q;
  assign cam.wr_word = in_go & (cw_q == CW_WORD);
  assign cam.wr_mask = in_go & (cw_q == CW_MASK);

  cam_array u_cam (
    .clk_in(clk_in),
    .arst_n_in(in_rst_n),
    .ce_in(ce_in),
    .cam(cam)
  );

  // Word write: take, commit, optional mask cycle
  always_ff @(posedge clk_in or negedge in_rst_n)
  begin
    if (!in_rst_n)
    begin
      cw_q <= CW_IDLE;
      cw_addr_q <= '0;
      cw_data_q <= '0;
      cw_dc_q <= 1'b0;
    end
    else if (in_go)
    begin
      case (cw_q)
        CW_IDLE:
        begin
          if (is_cam && we_e)
          begin
            cw_addr_q <= waddr_e[`CAM_ABITS-1:0];
            cw_data_q <= din_e;
            cw_dc_q <= dc_write_in;
            cw_q <= CW_WORD;
          end
        end
        CW_WORD:
        begin
          cw_q <= cw_dc_q ? CW_MASK : CW_IDLE;
        end
        CW_MASK:
        begin
          cw_q <= CW_IDLE;
        end
        default:
        begin
          cw_q <= CW_IDLE;
        end
      endcase
    end
  end
  assign busy_out = block_used_in & (cw_q != CW_IDLE);

  // Lowest matching index wins; duplicates make this ambiguous
  always_comb
  begin
    enc = '0;
    for (int i = `CAM_WORDS - 1; i >= 0; i--)
    begin
      if (hits_q[i])
      begin
        enc = 5'(i);
      end
    end
  end
  assign hit_any = |hits_q;

  // Half select: a new search restarts at the lower lines
  always_ff @(posedge clk_in or negedge out_rst_n)
  begin
    if (!out_rst_n)
    begin
      phase_q <= 1'b0;
    end
    else if (search)
    begin
      phase_q <= 1'b0;
    end
    else if (out_go && is_cam && !encode_sel_in)
    begin
      phase_q <= ~phase_q;
    end
  end

  // Output source by mode
  always_comb
  begin
    raw_upper = 1'b0;
    if (!is_cam)
    begin
      raw_data = rd_q;
    end
    else if (encode_sel_in)
    begin
      raw_data = {11'h000, enc};
    end
    else
    begin
      raw_upper = phase_q;
      raw_data = phase_q ? hits_q[31:16] : hits_q[15:0];
    end
  end

  // Low power trades one output-clock cycle of delay
  always_ff @(posedge clk_in or negedge out_rst_n)
  begin
    if (!out_rst_n)
    begin
      lp_data_q <= '0;
      lp_match_q <= 1'b0;
      lp_upper_q <= 1'b0;
    end
    else if (out_go)
    begin
      lp_data_q <= raw_data;
      lp_match_q <= is_cam & hit_any;
      lp_upper_q <= raw_upper;
    end
  end
  assign src_data = low_power_in ? lp_data_q : raw_data;
  assign src_match = low_power_in ? lp_match_q : (is_cam & hit_any);
  assign src_upper = low_power_in ? lp_upper_q : raw_upper;

  // Output registers on the output enable alone
  always_ff @(posedge clk_in or negedge out_rst_n)
  begin
    if (!out_rst_n)
    begin
      out_data_q <= '0;
      out_match_q <= 1'b0;
      out_upper_q <= 1'b0;
    end
    else if (out_go)
    begin
      out_data_q <= src_data;
      out_match_q <= src_match;
      out_upper_q <= src_upper;
    end
  end

  // Bypassed output skips its register; unused block drives zero
  always_comb
  begin
    data_out = '0;
    match_out = 1'b0;
    upper_half_out = 1'b0;
    if (block_used_in)
    begin
      data_out = bypass_in[`BYP_DOUT] ? src_data : out_data_q;
      match_out = bypass_in[`BYP_DOUT] ? src_match : out_match_q;
      upper_half_out = bypass_in[`BYP_DOUT] ? src_upper : out_upper_q;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in || in_clr_in || out_clr_in || glb_clr_in);

  a_word_write_len: assert property (
    cw_q == CW_IDLE && in_go && is_cam && we_e && !dc_write_in
    ##1 in_go[*1] |-> cw_q == CW_WORD ##1 cw_q == CW_IDLE)
    else $error("plain word write not two cycles");
  a_mask_write_len: assert property (
    cw_q == CW_IDLE && in_go && is_cam && we_e && dc_write_in
    ##1 in_go ##1 in_go |-> cw_q == CW_MASK ##1 cw_q == CW_IDLE)
    else $error("masked word write not three cycles");
  a_match_follows: assert property (
    out_go && !low_power_in && block_used_in |=>
    out_match_q == $past(is_cam && hit_any))
    else $error("match flag does not follow hits");
  a_no_hit_zero: assert property (
    is_cam && encode_sel_in && !hit_any |-> enc == '0)
    else $error("address not zero without a hit");
  a_unused_quiet: assert property (
    !block_used_in |-> data_out == '0 && !match_out && !busy_out)
    else $error("unused block drives outputs");
  a_rom_no_write: assert property (
    mode_in == MODE_ROM && !cfg_load_in |-> !wr_pulse)
    else $error("read-only contents written");
  a_single_port: assert property (
    mode_in == MODE_SINGLE && we_e |-> !rd_take)
    else $error("single port read during write");
  a_in_freeze: assert property (
    !in_ce_in |=> $stable(raddr_q) && $stable(hits_q))
    else $error("input group moved without its enable");
  a_out_freeze: assert property (
    !out_ce_in |=> $stable(out_data_q) && $stable(out_upper_q))
    else $error("output group moved without its enable");
  a_halves_order: assert property (
    search && !encode_sel_in ##1 out_go && is_cam && !search &&
    !encode_sel_in |=> phase_q)
    else $error("unencoded halves out of order");
endmodule : embedded_memory_block

// *** logic/emb_map.svh ***
// Constants for the embedded memory block: sizes, field positions, counts.
// Assumes inclusion by bare name from the package and design modules.
// Function
// - Input clock edge registers write data, enables and both addresses.
// - Output stage registers the data, match and upper-half outputs, under its own enable.
// - Input and output register groups have separate enables and clears.
// - All registers except the RAM and search word arrays clear asynchronously from local, global or chip reset.
// - Single-port mode shares one address port; reads yield to writes.
// - Search mode takes a word and returns the address holding it.
// - All stored words compared at once; match flag high on any hit.
// - Search mode holds 32 words of 32 bits.
// - Don't-care bits of a stored word never block a match.
// - Encoded output gives the binary address of the matching word.
// - Unencoded output shows 32 hit lines over 16 lines, two cycles.
// - Word write takes two cycles, three when don't-care bits written.
// - Each input and output register can be inserted or bypassed.
// - Write and read enables come from global or local sources.
// - Read-only mode keeps contents loaded at configuration.
// - Each block selects high speed or low power with added delay.
// - An unused block is powered down and draws nothing.
// - RAM shapes 128x16, 256x8, 512x4, 1024x2 and 2048x1.
// - Write pulse is generated inside from the input clock.
`ifndef EMB_MAP_SVH
`define EMB_MAP_SVH
`define RAM_ROWS 128
`define RAM_BITS 16
`define ADDR_BITS 11
`define ROW_BITS 7
`define DIN_BITS 32
`define CAM_WORDS 32
`define CAM_BITS 32
`define CAM_ABITS 5
`define UNENC_LINES 16
`define BYP_DIN 0
`define BYP_DOUT 1
`define BYP_RADDR 2
`define BYP_WADDR 3
`define BYP_WE 4
`define BYP_RS 5
`define BYP_BITS 6
`endif

// *** logic/emb_pkg.sv ***
// Types for the embedded memory block: modes, shapes, write states.
// Assumes emb_map.svh on the include path.
`include "emb_map.svh"
package emb_pkg;
  typedef enum logic [1:0] {
    MODE_IO_DUAL = 2'h0,
    MODE_SINGLE = 2'h1,
    MODE_CAM = 2'h2,
    MODE_ROM = 2'h3
  } mode_t;
  typedef enum logic [2:0] {
    SHAPE_128X16 = 3'h0,
    SHAPE_256X8 = 3'h1,
    SHAPE_512X4 = 3'h2,
    SHAPE_1024X2 = 3'h3,
    SHAPE_2048X1 = 3'h4
  } shape_t;
  typedef enum logic [2:0] {
    CW_IDLE = 3'b001,
    CW_WORD = 3'b010,
    CW_MASK = 3'b100
  } cam_wr_t;
endpackage : emb_pkg

// *** logic/cam_if.sv ***
// Connection between the block control and the search array.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`include "emb_map.svh"
interface cam_if;
  logic wr_word;
  logic wr_mask;
  logic [`CAM_ABITS-1:0] wr_addr;
  logic [`CAM_BITS-1:0] wr_data;
  logic [`CAM_BITS-1:0] key;
  logic [`CAM_WORDS-1:0] hit;
  modport array (input wr_word, wr_mask, wr_addr, wr_data, key,
    output hit);
  modport ctrl (output wr_word, wr_mask, wr_addr, wr_data, key,
    input hit);
endinterface : cam_if

// *** logic/cam_array.sv ***
// Search array: 32 stored words, don't-care masks, parallel compare.
// Assumes writes arrive as single-cycle strobes from the control FSM.
`timescale 1ns/100ps
`include "emb_map.svh"
module cam_array (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  cam_if.array cam
);
  logic [`CAM_BITS-1:0] word_q [`CAM_WORDS];
  logic [`CAM_BITS-1:0] dc_q [`CAM_WORDS];
  logic [`CAM_WORDS-1:0] valid_q;

  // Storage; a fresh word starts with no don't-care bits
  always_ff @(posedge clk_in)
  begin
    if (ce_in && cam.wr_word)
    begin
      word_q[cam.wr_addr] <= cam.wr_data;
      dc_q[cam.wr_addr] <= '0;
    end
    else if (ce_in && cam.wr_mask)
    begin
      dc_q[cam.wr_addr] <= cam.wr_data;
    end
  end

  // Valid bits keep never-written words from matching after reset
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      valid_q <= '0;
    end
    else if (ce_in && cam.wr_word)
    begin
      valid_q[cam.wr_addr] <= 1'b1;
    end
  end

  // Every word against the key at once, masked bits ignored
  always_comb
  begin
    for (int i = 0; i < `CAM_WORDS; i++)
    begin
      cam.hit[i] = valid_q[i] &&
        (((word_q[i] ^ cam.key) & ~dc_q[i]) == '0);
    end
  end
endmodule : cam_array

// *** test/fabric_model.sv ***
// Fabric logic model: drives the block's request pins through tasks.
// Assumes a free-running clk_in; the bench calls write and read.
`timescale 1ns/100ps
`include "emb_map.svh"
module fabric_model (
  input wire logic clk_in,
  input wire logic busy_in,
  output logic we_sel_out,
  output logic we_local_out,
  output logic we_global_out,
  output logic rs_sel_out,
  output logic rs_local_out,
  output logic rs_global_out,
  output logic dc_write_out,
  output logic [`DIN_BITS-1:0] data_out,
  output logic [`ADDR_BITS-1:0] wr_addr_out,
  output logic [`ADDR_BITS-1:0] rd_addr_out
);
  // Quiet pins at time zero
  initial
  begin
    {we_sel_out, we_local_out, we_global_out, dc_write_out} = 4'h0;
    {rs_sel_out, rs_local_out, rs_global_out} = 3'h0;
    data_out = 32'h0;
    wr_addr_out = 11'h0;
    rd_addr_out = 11'h0;
  end

  // One write; hi counts busy cycles, 8 means the block hung
  task automatic write(input logic [10:0] a, input logic [31:0] d,
    input logic dc, input logic [31:0] m, input logic g, output int hi);
    @(posedge clk_in);
    we_sel_out <= g;
    we_global_out <= g;
    we_local_out <= !g;
    wr_addr_out <= a;
    data_out <= d;
    dc_write_out <= dc;
    @(posedge clk_in);
    we_global_out <= 1'b0;
    we_local_out <= 1'b0;
    wr_addr_out <= ~a;
    @(posedge clk_in);
    data_out <= dc ? m : ~d;
    // No new request while busy, so no write is refused
    hi = 0;
    while (hi < 8)
    begin
      @(negedge clk_in);
      if (!busy_in)
        break;
      hi++;
    end
  endtask : write

  // One read or search; returns where the result has settled
  task automatic read(input logic [31:0] k, input logic [10:0] a,
    input logic g, input int lat);
    @(posedge clk_in);
    rs_sel_out <= g;
    rs_global_out <= g;
    rs_local_out <= !g;
    rd_addr_out <= a;
    // Single-port reads take the shared write address
    wr_addr_out <= a;
    data_out <= k;
    @(posedge clk_in);
    rs_global_out <= 1'b0;
    rs_local_out <= 1'b0;
    repeat (lat) @(posedge clk_in);
    @(negedge clk_in);
  endtask : read
endmodule : fabric_model

// *** test/tb.sv ***
// Self-checking bench for the embedded memory block.
// Assumes the fabric model drives requests; results compared in order.
`timescale 1ns/100ps
module tb;
  import emb_pkg::*;
  logic clk_in, arst_n_in, in_ce_in, out_ce_in, out_clr_in, in_clr_in;
  logic [5:0] bypass_in;
  logic encode_sel_in, low_power_in, block_used_in, cfg_load_in;
  mode_t mode_in;
  shape_t shape_in;
  logic we_sel, we_loc, we_glb, rs_sel, rs_loc, rs_glb, dc_wr;
  logic [31:0] din, d, w;
  logic [10:0] wr_addr, rd_addr;
  logic [15:0] dout;
  logic match, upper, busy;
  logic [16:0] notes[$];
  logic [15:0] wd[4];
  logic [10:0] wa[4];
  event look;
  int errors, check_count, seed, i;

  fabric_model fabric_model_i (.clk_in(clk_in), .busy_in(busy),
    .we_sel_out(we_sel), .we_local_out(we_loc), .we_global_out(we_glb),
    .rs_sel_out(rs_sel), .rs_local_out(rs_loc), .rs_global_out(rs_glb),
    .dc_write_out(dc_wr), .data_out(din), .wr_addr_out(wr_addr),
    .rd_addr_out(rd_addr));

  // Global clock enable held active and global clear held inactive
  embedded_memory_block embedded_memory_block_i (.clk_in(clk_in),
    .arst_n_in(arst_n_in), .ce_in(1'b1), .in_ce_in(in_ce_in),
    .out_ce_in(out_ce_in), .in_clr_in(in_clr_in), .out_clr_in(out_clr_in),
    .glb_clr_in(1'b0), .mode_in(mode_in), .shape_in(shape_in),
    .bypass_in(bypass_in), .encode_sel_in(encode_sel_in),
    .low_power_in(low_power_in), .block_used_in(block_used_in),
    .cfg_load_in(cfg_load_in), .we_sel_in(we_sel), .we_local_in(we_loc),
    .we_global_in(we_glb), .rs_sel_in(rs_sel),
    .read_strobe_local_in(rs_loc), .read_strobe_global_in(rs_glb),
    .dc_write_in(dc_wr), .data_in(din), .wr_addr_in(wr_addr),
    .rd_addr_in(rd_addr), .data_out(dout), .match_out(match),
    .upper_half_out(upper), .busy_out(busy));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  task automatic note(input logic [16:0] e);
    notes.push_back(e);
    -> look;
  endtask : note

  task automatic wr(input logic [10:0] a, input logic [31:0] dd,
    input logic dc, input logic [31:0] m, input int hi_exp);
    int hi;
    fabric_model_i.write(a, dd, dc, m, 1'($random(seed)), hi);
    check(hi, hi_exp);
    if (hi >= 8)
      summarize();
  endtask : wr

  task automatic rd(input logic [31:0] k, input logic [10:0] a,
    input int lat, input logic [16:0] e);
    fabric_model_i.read(k, a, 1'($random(seed)), lat);
    note(e);
  endtask : rd

  // Free-running 10 MHz clock
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // Cuts a hang short
  initial
  begin
    #1000000;
    errors++;
    summarize();
  end

  // Oldest note against the outputs each time a result settles
  initial
  begin
    forever
    begin
      @(look);
      check({15'h0, match, dout}, {15'h0, notes.pop_front()});
    end
  end

  // Main sequence: RAM paths and enables first, then search mode
  initial
  begin
    seed = 93;
    {arst_n_in, out_clr_in, low_power_in, cfg_load_in} = 4'h0;
    {in_clr_in, bypass_in} = 7'h00;
    {in_ce_in, out_ce_in, block_used_in, encode_sel_in} = 4'hf;
    mode_in = MODE_IO_DUAL;
    shape_in = SHAPE_128X16;
    repeat (6) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(negedge clk_in);
    note(17'h0);
    for (i = 0; i < 4; i++)
    begin
      d = $random(seed);
      wa[i] = {4'h0, 2'(i), 5'($random(seed))};
      wd[i] = d[15:0];
      wr(wa[i], d, 1'b0, 32'h0, 0);
    end
    for (i = 0; i < 4; i++)
      rd(32'h0, wa[i], 2, {1'b0, wd[i]});
    // Low power: old word still shown one cycle longer
    @(posedge clk_in);
    low_power_in <= 1'b1;
    rd(32'h0, wa[0], 2, {1'b0, wd[3]});
    @(negedge clk_in);
    note({1'b0, wd[0]});
    // Output side frozen while the input side still reads
    @(posedge clk_in);
    low_power_in <= 1'b0;
    out_ce_in <= 1'b0;
    rd(32'h0, wa[1], 2, {1'b0, wd[0]});
    @(posedge clk_in);
    out_ce_in <= 1'b1;
    @(negedge clk_in);
    @(negedge clk_in);
    note({1'b0, wd[1]});
    // Input side disabled, then ROM without load: writes dropped
    @(posedge clk_in);
    in_ce_in <= 1'b0;
    wr(wa[2], ~{16'h0, wd[2]}, 1'b0, 32'h0, 0);
    @(posedge clk_in);
    in_ce_in <= 1'b1;
    mode_in <= MODE_ROM;
    wr(wa[3], ~{16'h0, wd[3]}, 1'b0, 32'h0, 0);
    rd(32'h0, wa[2], 2, {1'b0, wd[2]});
    rd(32'h0, wa[3], 2, {1'b0, wd[3]});
    @(posedge clk_in);
    cfg_load_in <= 1'b1;
    d = $random(seed);
    wr(wa[3], d, 1'b0, 32'h0, 0);
    @(posedge clk_in);
    cfg_load_in <= 1'b0;
    rd(32'h0, wa[3], 2, {1'b0, d[15:0]});
    // Unused block shows zero; clears act without a clock edge
    @(posedge clk_in);
    block_used_in <= 1'b0;
    @(negedge clk_in);
    note(17'h0);
    @(posedge clk_in);
    block_used_in <= 1'b1;
    @(posedge clk_in);
    out_clr_in <= 1'b1;
    #1 note(17'h0);
    @(posedge clk_in);
    out_clr_in <= 1'b0;
    // Input clear leaves the output group alone until its next edge
    @(posedge clk_in);
    in_clr_in <= 1'b1;
    #1 note({1'b0, d[15:0]});
    @(posedge clk_in);
    in_clr_in <= 1'b0;
    @(negedge clk_in);
    note(17'h0);
    // Single port, byte shape: both lanes of one row, then bypassed
    @(posedge clk_in);
    mode_in <= MODE_SINGLE;
    shape_in <= SHAPE_256X8;
    d = $random(seed);
    wr(11'h0a1, d, 1'b0, 32'h0, 0);
    wr(11'h0a0, ~d, 1'b0, 32'h0, 0);
    rd(32'h0, 11'h0a1, 2, {9'h0, d[7:0]});
    rd(32'h0, 11'h0a0, 2, {9'h0, ~d[7:0]});
    @(posedge clk_in);
    bypass_in <= 6'h3f;
    wr(11'h0a0, d, 1'b0, 32'h0, 0);
    rd(32'h0, 11'h0a0, 0, {9'h0, d[7:0]});
    // Search mode: plain word at 12, masked word at 5
    @(posedge clk_in);
    bypass_in <= 6'h00;
    mode_in <= MODE_CAM;
    w = $random(seed);
    d = $random(seed);
    wr(11'd12, w, 1'b0, 32'h0, 1);
    wr(11'd5, d, 1'b1, 32'h0000ffff, 2);
    rd(w, 11'h0, 2, {1'b1, 16'd12});
    rd(d ^ 32'h0000a5ff, 11'h0, 2, {1'b1, 16'd5});
    rd(d ^ 32'h00010000, 11'h0, 2, 17'h0);
    // Same word in three places only with unencoded output
    w = ~w;
    wr(11'd3, w, 1'b0, 32'h0, 1);
    wr(11'd20, w, 1'b0, 32'h0, 1);
    wr(11'd31, w, 1'b0, 32'h0, 1);
    @(posedge clk_in);
    encode_sel_in <= 1'b0;
    rd(w, 11'h0, 2, {1'b1, 16'h0008});
    @(negedge clk_in);
    note({1'b1, 16'h8010});
    check(upper, 1'b1);
    // Let the watcher take the last note before the verdict
    @(posedge clk_in);
    check(notes.size(), 0);
    summarize();
  end
endmodule : tb
